/* src/udb_pkg.sv */
/*
 * Shared constants of the debug port request engine and its console partner:
 * register offsets, field positions, reset values, PID codes and timing.
 * Assumes a 250 MHz clock and an 8-bit APB address.
 */
package udb_pkg;
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] CTRL_OFS = 8'hA0;
    localparam logic [APB_AW-1:0] PID_OFS = 8'hA4;
    localparam logic [APB_AW-1:0] BUF_LO_OFS = 8'hA8;
    localparam logic [APB_AW-1:0] BUF_HI_OFS = 8'hAC;
    localparam logic [APB_AW-1:0] CFG_OFS = 8'hB0;

    localparam int DONE_BIT = 16;
    localparam int CLAIM_BIT = 10;
    localparam int CODE_LSB = 7;
    localparam int ERR_BIT = 6;
    localparam int START_BIT = 5;
    localparam int DIR_BIT = 4;
    localparam int LEN_LSB = 0;
    localparam int RPID_LSB = 16;
    localparam int SPID_LSB = 8;
    localparam int TPID_LSB = 0;
    localparam int CFG_ADDR_LSB = 8;
    localparam int CFG_EP_LSB = 0;
    localparam int WORD_HI_LSB = 32;

    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_XACT = 3'h1;
    localparam logic [2:0] CODE_HW = 3'h2;
    localparam logic [6:0] ADDR_RESET = 7'h7F;
    localparam logic [3:0] EP_RESET = 4'h1;
    localparam logic [3:0] LEN_RESET = 4'h0;
    localparam logic [7:0] PID_RESET = 8'h00;
    localparam logic [3:0] MAX_LEN = 4'h8;
    localparam int BUF_BYTES = 8;

    localparam logic [7:0] PID_OUT = 8'hE1;
    localparam logic [7:0] PID_IN = 8'h69;
    localparam logic [7:0] PID_SETUP = 8'h2D;
    localparam logic [7:0] PID_ACK = 8'hD2;
    localparam logic [7:0] PID_NAK = 8'h5A;

    localparam int CLK_PERIOD_NS = 4;
    localparam int RSP_TIMEOUT_NS = 400;
    localparam int RSP_TIMEOUT_CYC = (RSP_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
        RSP_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int WAIT_W = 8;

    // A PID carries its own check nibble, the complement of the type nibble.
    function automatic logic pid_ok(input logic [7:0] pid);
        pid_ok = (pid[7:4] == ~pid[3:0]);
    endfunction
endpackage

/* src/udb_link_if.sv */
/*
 * Byte stream link between the request engine and the debug console.
 * Assumes both ends run on one clock; packets go out one byte per cycle
 * with no gap, and a gap inside a packet aborts it.
 */
`timescale 1ns/100ps
interface udb_link_if;
    logic h_valid;
    logic [7:0] h_byte;
    logic h_last;
    logic c_valid;
    logic [7:0] c_byte;
    logic c_last;

    modport engine (
        output h_valid,
        output h_byte,
        output h_last,
        input c_valid,
        input c_byte,
        input c_last
    );

    modport console (
        input h_valid,
        input h_byte,
        input h_last,
        output c_valid,
        output c_byte,
        output c_last
    );
endinterface

/* src/udb_request_engine.sv */
/*
 * Debug port request engine: APB register file, one token, data and
 * handshake exchange per started request over the byte stream link.
 * Assumes a synchronous APB master and the port state flags on one clock.
 */
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - Claimed flag bit 10, software only
// - Failure code bits 9:7, valid with error
// - Failed exchange reports transaction error code
// - Suspend or reset during request: hardware error
// - Error flag set on failure, cleared on success; a suspend or reset in the reply's final cycle still clears it
// - Start runs request, clears with completion
// - Software never restarts while start is set
// - Direction bit selects read or write
// - Write sends zero to eight buffer bytes
// - Software never programs write length above eight
// - Read returns received count, never above eight
// - Bytes move from byte 0 upward
// - Reserved bits read zero, writes ignored
// - Software writes back reserved bits as read
// - Returned PID field holds received PID
// - Returned PID final before start clears
// - Write data packet opens with data PID
// - Every token carries the token PID
// - Completion flag set at end, write-one-clear
// - Eight byte buffer, byte 0 lowest
// - Token address from field defaulting 7Fh
module udb_request_engine (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [udb_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_suspended,
    input wire logic port_reset,
    udb_link_if.engine link
);
    import udb_pkg::*;

    typedef enum {S_IDLE, S_TOK_ADDR, S_TOK_EP, S_DAT_PID, S_DAT_BYTE, S_WAIT, S_RECV}
        udb_host_e;

    udb_host_e state_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic port_claimed_flag_r, request_failed_flag_r, request_start_r;
    logic direction_select_r, request_complete_flag_r;
    logic [2:0] failure_code_r;
    logic [3:0] byte_count_r, idx_r;
    logic [7:0] returned_pid_r, outgoing_data_pid_r, outgoing_token_pid_r;
    logic [7:0] payload_buffer_r [BUF_BYTES];
    logic [6:0] target_device_address_r;
    logic [3:0] target_endpoint_r;
    logic [WAIT_W-1:0] wait_r;
    logic h_valid_r, h_last_r;
    logic [7:0] h_byte_r;
    logic setup_ph, acc, wr_acc, go, port_bad, fail_hw, fail_x, ok_end, end_any;
    logic [63:0] buf_flat;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign link.h_valid = h_valid_r;
    assign link.h_byte = h_byte_r;
    assign link.h_last = h_last_r;

    assign setup_ph = psel && penable && !pready_r;
    assign acc = psel && penable && pready_r;
    assign wr_acc = acc && pwrite;
    assign port_bad = port_suspended || port_reset;
    assign go = wr_acc && paddr == CTRL_OFS && pwdata[START_BIT] && !request_start_r;

    always_comb begin
        for (int i = 0; i < BUF_BYTES; i++) begin
            buf_flat[i*8 +: 8] = payload_buffer_r[i];
        end
    end

    // End of the exchange, decided from the link and the port state.
    always_comb begin
        fail_hw = port_bad && (request_start_r || go);
        fail_x = 1'b0;
        ok_end = 1'b0;
        case (state_r)
            S_WAIT: begin
                if (link.c_valid) begin
                    if (!pid_ok(link.c_byte) || (direction_select_r && !link.c_last)) begin
                        fail_x = 1'b1;
                    end else begin
                        ok_end = link.c_last;
                    end
                end else begin
                    fail_x = (wait_r == '0);
                end
            end
            S_RECV: begin
                if (!link.c_valid || idx_r == MAX_LEN) begin
                    fail_x = 1'b1;
                end else begin
                    ok_end = link.c_last;
                end
            end
            default: ;
        endcase
        end_any = fail_hw || fail_x || ok_end;
    end

    // APB slave: one wait cycle, data and error registered.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            if (setup_ph) begin
                case (paddr)
                    CTRL_OFS: begin
                        if (!pwrite) begin
                            prdata_r[DONE_BIT] <= request_complete_flag_r;
                            prdata_r[CLAIM_BIT] <= port_claimed_flag_r;
                            prdata_r[CODE_LSB +: 3] <= failure_code_r;
                            prdata_r[ERR_BIT] <= request_failed_flag_r;
                            prdata_r[START_BIT] <= request_start_r;
                            prdata_r[DIR_BIT] <= direction_select_r;
                            prdata_r[LEN_LSB +: 4] <= byte_count_r;
                        end
                    end
                    PID_OFS: begin
                        if (!pwrite) begin
                            prdata_r[RPID_LSB +: 8] <= returned_pid_r;
                            prdata_r[SPID_LSB +: 8] <= outgoing_data_pid_r;
                            prdata_r[TPID_LSB +: 8] <= outgoing_token_pid_r;
                        end
                    end
                    BUF_LO_OFS: begin
                        if (!pwrite) begin
                            prdata_r <= buf_flat[0 +: 32];
                        end
                    end
                    BUF_HI_OFS: begin
                        if (!pwrite) begin
                            prdata_r <= buf_flat[WORD_HI_LSB +: 32];
                        end
                    end
                    CFG_OFS: begin
                        if (!pwrite) begin
                            prdata_r[CFG_ADDR_LSB +: 7] <= target_device_address_r;
                            prdata_r[CFG_EP_LSB +: 4] <= target_endpoint_r;
                        end
                    end
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    // Control and status fields.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_claimed_flag_r <= 1'b0;
            request_failed_flag_r <= 1'b0;
            failure_code_r <= CODE_NONE;
            request_start_r <= 1'b0;
            direction_select_r <= 1'b0;
            byte_count_r <= LEN_RESET;
            request_complete_flag_r <= 1'b0;
        end else begin
            if (wr_acc && paddr == CTRL_OFS) begin
                port_claimed_flag_r <= pwdata[CLAIM_BIT];
                if (!request_start_r) begin
                    direction_select_r <= pwdata[DIR_BIT];
                    byte_count_r <= pwdata[LEN_LSB +: 4];
                end
                if (pwdata[DONE_BIT]) begin
                    request_complete_flag_r <= 1'b0;
                end
            end
            if (end_any) begin
                request_start_r <= 1'b0;
                request_complete_flag_r <= 1'b1;
                request_failed_flag_r <= !ok_end;
                failure_code_r <= fail_hw ? CODE_HW : (fail_x ? CODE_XACT : CODE_NONE);
                if (ok_end && !direction_select_r) begin
                    byte_count_r <= (state_r == S_RECV) ? idx_r + 4'h1 : LEN_RESET;
                end
            end else if (go) begin
                request_start_r <= 1'b1;
            end
        end
    end

    // PID register, configuration and data buffer.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            returned_pid_r <= PID_RESET;
            outgoing_data_pid_r <= PID_RESET;
            outgoing_token_pid_r <= PID_RESET;
            target_device_address_r <= ADDR_RESET;
            target_endpoint_r <= EP_RESET;
            for (int i = 0; i < BUF_BYTES; i++) begin
                payload_buffer_r[i] <= '0;
            end
        end else begin
            if (wr_acc && paddr == PID_OFS) begin
                outgoing_data_pid_r <= pwdata[SPID_LSB +: 8];
                outgoing_token_pid_r <= pwdata[TPID_LSB +: 8];
            end
            if (wr_acc && paddr == CFG_OFS) begin
                target_device_address_r <= pwdata[CFG_ADDR_LSB +: 7];
                target_endpoint_r <= pwdata[CFG_EP_LSB +: 4];
            end
            for (int i = 0; i < BUF_BYTES / 2; i++) begin
                if (wr_acc && paddr == BUF_LO_OFS) begin
                    payload_buffer_r[i] <= pwdata[i*8 +: 8];
                end
                if (wr_acc && paddr == BUF_HI_OFS) begin
                    payload_buffer_r[i + BUF_BYTES / 2] <= pwdata[i*8 +: 8];
                end
            end
            if (state_r == S_WAIT && link.c_valid) begin
                returned_pid_r <= link.c_byte;
            end
            if (state_r == S_RECV && link.c_valid && idx_r != MAX_LEN) begin
                payload_buffer_r[idx_r[2:0]] <= link.c_byte;
            end
        end
    end

    // Reply timeout, reloaded whenever no reply is awaited.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_r <= WAIT_W'(RSP_TIMEOUT_CYC);
        end else if (state_r == S_WAIT) begin
            wait_r <= wait_r - 1'b1;
        end else begin
            wait_r <= WAIT_W'(RSP_TIMEOUT_CYC);
        end
    end

    // Exchange sequencer: token, optional data packet, then the reply.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= S_IDLE;
            idx_r <= '0;
            h_valid_r <= 1'b0;
            h_byte_r <= '0;
            h_last_r <= 1'b0;
        end else if (end_any) begin
            state_r <= S_IDLE;
            h_valid_r <= 1'b0;
            h_last_r <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (go) begin
                        h_valid_r <= 1'b1;
                        h_byte_r <= outgoing_token_pid_r;
                        h_last_r <= 1'b0;
                        state_r <= S_TOK_ADDR;
                    end
                end
                S_TOK_ADDR: begin
                    h_byte_r <= {1'b0, target_device_address_r};
                    state_r <= S_TOK_EP;
                end
                S_TOK_EP: begin
                    h_byte_r <= {4'h0, target_endpoint_r};
                    h_last_r <= 1'b1;
                    state_r <= direction_select_r ? S_DAT_PID : S_WAIT;
                end
                S_DAT_PID: begin
                    h_byte_r <= outgoing_data_pid_r;
                    h_last_r <= (byte_count_r == LEN_RESET);
                    idx_r <= '0;
                    state_r <= (byte_count_r == LEN_RESET) ? S_WAIT : S_DAT_BYTE;
                end
                S_DAT_BYTE: begin
                    h_byte_r <= payload_buffer_r[idx_r[2:0]];
                    h_last_r <= (idx_r + 4'h1 == byte_count_r);
                    idx_r <= idx_r + 4'h1;
                    if (idx_r + 4'h1 == byte_count_r) begin
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    h_valid_r <= 1'b0;
                    h_last_r <= 1'b0;
                    idx_r <= '0;
                    if (link.c_valid) begin
                        state_r <= S_RECV;
                    end
                end
                S_RECV: begin
                    idx_r <= idx_r + 4'h1;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // udb_request_engine

/* src/udb_console.sv */
/*
 * Debug console end of the link: decodes tokens, takes OUT and SETUP data,
 * answers IN tokens with user data or NAK, and handshakes OUT data.
 * Assumes the engine sends packets back to back and waits for each reply.
 */
`timescale 1ns/100ps
module udb_console (
    input wire logic clock,
    input wire logic resetn,
    udb_link_if.console link,
    input wire logic [6:0] own_address,
    input wire logic [3:0] own_endpoint,
    input wire logic tx_ready,
    input wire logic [7:0] tx_pid,
    input wire logic [3:0] tx_len,
    input wire logic [63:0] tx_data,
    input wire logic rx_busy,
    output logic tx_sent,
    output logic rx_valid,
    output logic [7:0] rx_token_pid,
    output logic [7:0] rx_pid,
    output logic [3:0] rx_len,
    output logic [63:0] rx_data
);
    import udb_pkg::*;

    typedef enum {C_TOK, C_ADDR, C_EP, C_DPID, C_DBYTE, C_HS, C_TXPID, C_TXBYTE}
        udb_dev_e;

    udb_dev_e state_r;
    logic [7:0] tok_r, pid_r, c_byte_r;
    logic [6:0] addr_r;
    logic [3:0] idx_r, len_r;
    logic [63:0] data_r;
    logic c_valid_r, c_last_r, tx_sent_r, rx_valid_r;

    assign link.c_valid = c_valid_r;
    assign link.c_byte = c_byte_r;
    assign link.c_last = c_last_r;
    assign tx_sent = tx_sent_r;
    assign rx_valid = rx_valid_r;
    assign rx_token_pid = tok_r;
    assign rx_pid = pid_r;
    assign rx_len = len_r;
    assign rx_data = data_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= C_TOK;
            tok_r <= PID_RESET;
            pid_r <= PID_RESET;
            addr_r <= '0;
            idx_r <= '0;
            len_r <= LEN_RESET;
            data_r <= '0;
            c_valid_r <= 1'b0;
            c_byte_r <= '0;
            c_last_r <= 1'b0;
            tx_sent_r <= 1'b0;
            rx_valid_r <= 1'b0;
        end else begin
            tx_sent_r <= 1'b0;
            rx_valid_r <= 1'b0;
            case (state_r)
                C_TOK: begin
                    c_valid_r <= 1'b0;
                    c_last_r <= 1'b0;
                    if (link.h_valid && !link.h_last && pid_ok(link.h_byte)) begin
                        tok_r <= link.h_byte;
                        state_r <= C_ADDR;
                    end
                end
                C_ADDR: begin
                    addr_r <= link.h_byte[6:0];
                    state_r <= (link.h_valid && !link.h_last) ? C_EP : C_TOK;
                end
                C_EP: begin
                    state_r <= C_TOK;
                    if (link.h_valid && link.h_last && addr_r == own_address &&
                        link.h_byte[3:0] == own_endpoint) begin
                        if (tok_r == PID_IN) begin
                            state_r <= tx_ready ? C_TXPID : C_HS;
                            pid_r <= PID_NAK;
                        end else if (tok_r == PID_OUT || tok_r == PID_SETUP) begin
                            state_r <= C_DPID;
                        end
                    end
                end
                C_DPID: begin
                    idx_r <= '0;
                    pid_r <= link.h_byte;
                    if (!link.h_valid) begin
                        state_r <= C_TOK;
                    end else if (link.h_last) begin
                        len_r <= LEN_RESET;
                        state_r <= C_HS;
                    end else begin
                        state_r <= C_DBYTE;
                    end
                end
                C_DBYTE: begin
                    if (!link.h_valid || idx_r == MAX_LEN) begin
                        state_r <= C_TOK;
                    end else begin
                        data_r[idx_r[2:0]*8 +: 8] <= link.h_byte;
                        idx_r <= idx_r + 4'h1;
                        if (link.h_last) begin
                            len_r <= idx_r + 4'h1;
                            state_r <= C_HS;
                        end
                    end
                end
                C_HS: begin
                    c_valid_r <= 1'b1;
                    c_last_r <= 1'b1;
                    if (tok_r == PID_IN || rx_busy) begin
                        c_byte_r <= PID_NAK;
                    end else begin
                        c_byte_r <= PID_ACK;
                        rx_valid_r <= 1'b1;
                    end
                    state_r <= C_TOK;
                end
                C_TXPID: begin
                    c_valid_r <= 1'b1;
                    c_byte_r <= tx_pid;
                    c_last_r <= (tx_len == LEN_RESET);
                    idx_r <= '0;
                    len_r <= (tx_len > MAX_LEN) ? MAX_LEN : tx_len;
                    tx_sent_r <= (tx_len == LEN_RESET);
                    state_r <= (tx_len == LEN_RESET) ? C_TOK : C_TXBYTE;
                end
                C_TXBYTE: begin
                    c_byte_r <= tx_data[idx_r[2:0]*8 +: 8];
                    c_last_r <= (idx_r + 4'h1 == len_r);
                    idx_r <= idx_r + 4'h1;
                    if (idx_r + 4'h1 == len_r) begin
                        tx_sent_r <= 1'b1;
                        state_r <= C_TOK;
                    end
                end
                default: state_r <= C_TOK;
            endcase
        end
    end
endmodule // udb_console

/* test/udb_link_asserts.sv */
/* Checker for the byte stream link: packet framing and reply timing.
   Assumes it sees the interface signals and the engine's clock and reset. */
`timescale 1ns/100ps
module udb_link_asserts (
    input wire logic clock,
    input wire logic resetn,
    input wire logic h_valid,
    input wire logic [7:0] h_byte,
    input wire logic h_last,
    input wire logic c_valid,
    input wire logic [7:0] c_byte,
    input wire logic c_last
);
    import udb_pkg::*;
    logic [4:0] h_run_r;
    logic [4:0] c_run_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Counts the bytes of each unbroken valid run on each direction.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            h_run_r <= 5'h00;
            c_run_r <= 5'h00;
        end else begin
            h_run_r <= h_valid ? h_run_r + 5'h01 : 5'h00;
            c_run_r <= c_valid ? c_run_r + 5'h01 : 5'h00;
        end
    end
    a_hlast_framed: assert property (h_last |-> h_valid)
        else $error("host last outside a packet");
    a_token_shape: assert property ($rose(h_valid) |-> !h_last
        ##1 (h_valid && !h_last && !h_byte[7]) ##1 (h_valid && h_last && h_byte[7:4] == 4'h0))
        else $error("token packet malformed");
    a_no_overlap: assert property (h_valid |-> !c_valid)
        else $error("both ends drive at once");
    a_reply_timing: assert property ($rose(c_valid) |-> $past(h_last, 2))
        else $error("reply not right after host packet");
    a_reply_framed: assert property ($fell(c_valid) |-> $past(c_last))
        else $error("reply packet has a gap");
    a_reply_once: assert property (c_last |=> !c_valid)
        else $error("reply runs past its last byte");
    a_write_len: assert property (h_run_r <= 5'h0C)
        else $error("host sent too many bytes");
    a_read_len: assert property (c_run_r <= 5'h09)
        else $error("reply longer than eight data bytes");
    a_reply_pid: assert property ($rose(c_valid) |-> pid_ok(c_byte))
        else $error("reply PID check fails");
    c_reply: cover property ($rose(c_valid));
    c_full_write: cover property (h_run_r == 5'h0C);
    c_full_read: cover property (c_run_r == 5'h09);
endmodule // udb_link_asserts

/* test/testbench.sv */
/* Testbench: engine and console joined by the link, driven over APB.
   Assumes the package constants and the one-wait-state APB slave. */
`timescale 1ns/100ps
module testbench;
    import udb_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic susp = 1'b0, prst = 1'b0, tx_ready = 1'b1;
    logic tx_sent, rx_valid;
    int rx_seen = 0, tx_seen = 0;
    logic [6:0] own_addr = 7'h7F;
    logic [7:0] tx_pid = 8'h4B, rx_token_pid, rx_pid;
    logic [3:0] tx_len = 4'h0, rx_len, ln;
    logic [63:0] tx_data = 64'hF0E0D0C0B0A09080, rx_data, mask;
    int failures = 0, cmp_count = 0;
    always #2 clock = ~clock;
    udb_link_if lk();
    udb_request_engine udb_request_engine_i (.clock(clock), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_suspended(susp), .port_reset(prst),
        .link(lk.engine));
    udb_console udb_console_i (.clock(clock), .resetn(resetn), .link(lk.console),
        .own_address(own_addr), .own_endpoint(4'h1), .tx_ready(tx_ready), .tx_pid(tx_pid),
        .tx_len(tx_len), .tx_data(tx_data), .rx_busy(1'b0), .tx_sent(tx_sent),
        .rx_valid(rx_valid),
        .rx_token_pid(rx_token_pid), .rx_pid(rx_pid), .rx_len(rx_len), .rx_data(rx_data));
    udb_link_asserts udb_link_asserts_i (.clock(clock), .resetn(resetn),
        .h_valid(lk.h_valid), .h_byte(lk.h_byte), .h_last(lk.h_last),
        .c_valid(lk.c_valid), .c_byte(lk.c_byte), .c_last(lk.c_last));
    // Counts the console's delivery pulses for OUT data and IN replies.
    always @(posedge clock) begin
        if (rx_valid === 1'b1) begin
            rx_seen++;
        end
        if (tx_sent === 1'b1) begin
            tx_seen++;
        end
    end
    task automatic tally_and_finish;
        $display("TB: %0d compares, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer; q and e hold read data and error of the answer.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("BAD %0t no bus answer", $time);
            failures++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // Clears done, starts a request and polls until done is set.
    task automatic go(input logic [31:0] cmd);
        int n;
        n = 0;
        xfer(1'b1, CTRL_OFS, 32'h00010000 | cmd);
        do begin
            xfer(1'b0, CTRL_OFS, 32'h0);
            n++;
        end while (q[DONE_BIT] !== 1'b1 && n < 100);
        if (q[DONE_BIT] !== 1'b1) begin
            $display("BAD %0t request never completes", $time);
            failures++;
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rdchk(CTRL_OFS, 32'h0);
        rdchk(CFG_OFS, 32'h00007F01);
        xfer(1'b1, PID_OFS, 32'hFFFFFFFF);
        rdchk(PID_OFS, 32'h0000FFFF);
        xfer(1'b1, CTRL_OFS, 32'h00000400);
        rdchk(CTRL_OFS, 32'h00000400);
        xfer(1'b0, 8'h00, 32'h0);
        chk(e, 1'b1);
        $display("TB: register test ends");
        xfer(1'b1, BUF_LO_OFS, 32'h44332211);
        xfer(1'b1, BUF_HI_OFS, 32'h88776655);
        xfer(1'b1, PID_OFS, 32'h0000C3E1);
        for (int i = 0; i < 3; i++) begin
            ln = 4'(i * 4);
            mask = ~(64'hFFFFFFFFFFFFFFFF << (ln * 8));
            go(32'h30 | ln);
            chk(q, 32'h00010010 | ln);
            chk(rx_data & mask, 64'h8877665544332211 & mask);
            chk({rx_len, rx_pid, rx_token_pid}, {ln, 8'hC3, PID_OUT});
            rdchk(PID_OFS, {8'h00, PID_ACK, 16'hC3E1});
        end
        chk(rx_seen, 3);
        $display("TB: write test ends");
        xfer(1'b1, PID_OFS, 32'h00000069);
        for (int i = 0; i < 3; i++) begin
            tx_len <= (i == 0) ? 4'h5 : 4'hF;
            tx_ready <= (i < 2);
            go(32'h20);
            chk(q, (i == 0) ? 32'h10005 : (i == 1) ? 32'h10008 : 32'h10000);
            rdchk(PID_OFS, {8'h00, (i < 2) ? 8'h4B : PID_NAK, 16'h0069});
            rdchk(BUF_LO_OFS, 32'hB0A09080);
        end
        rdchk(BUF_HI_OFS, 32'hF0E0D0C0);
        chk(tx_seen, 2);
        $display("TB: read test ends");
        own_addr <= 7'h10;
        go(32'h20);
        chk(q, 32'h000100C0);
        own_addr <= 7'h7F;
        for (int i = 0; i < 2; i++) begin
            susp <= (i == 0);
            prst <= (i == 1);
            go(32'h20);
            chk(q, 32'h00010140);
        end
        susp <= 1'b0;
        prst <= 1'b0;
        tx_ready <= 1'b1;
        tx_len <= 4'h2;
        go(32'h20);
        chk(q & 32'h0001007F, 32'h00010002);
        xfer(1'b1, CTRL_OFS, 32'h00010000);
        rdchk(CTRL_OFS, 32'h0);
        chk(q[DONE_BIT], 1'b0);
        $display("TB: error test ends");
        tally_and_finish();
    end
endmodule // testbench
